// ===== src/ncc_pkg.sv
/*
 * ncc_pkg: constants, field layouts and carrier types for the common
 * configuration register bank of the network controller.
 * assumes a 40 MHz system clock and byte-wide register access.
 */
package ncc_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_SUMMARY_FLAGS = 16'h0015;
    localparam logic [15:0] ADDR_INTERRUPT_MASK = 16'h0016;
    localparam logic [15:0] ADDR_RETRY_INTERVAL_HI = 16'h0017;
    localparam logic [15:0] ADDR_RETRY_INTERVAL_LO = 16'h0018;
    localparam logic [15:0] ADDR_RETRY_LIMIT = 16'h0019;
    localparam logic [15:0] ADDR_RX_BUFFER_SPLIT = 16'h001a;
    localparam logic [15:0] ADDR_TX_BUFFER_SPLIT = 16'h001b;
    localparam logic [15:0] ADDR_PPP_AUTH_KIND_HI = 16'h001c;
    localparam logic [15:0] ADDR_PPP_AUTH_KIND_LO = 16'h001d;
    localparam logic [15:0] ADDR_LCP_ECHO_INTERVAL = 16'h0028;
    localparam logic [15:0] ADDR_LCP_MAGIC_VALUE = 16'h0029;
    localparam logic [15:0] ADDR_UNREACHABLE_IP = 16'h002a;
    localparam logic [15:0] ADDR_UNREACHABLE_PORT = 16'h002e;
    localparam logic [15:0] ADDR_SOCKET_MODE = 16'h0400;
    localparam logic [15:0] SOCKET_STRIDE = 16'h0100;

    // reset values
    localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
    localparam logic [15:0] RST_RETRY_INTERVAL = 16'h07d0;
    localparam logic [7:0] RST_RETRY_LIMIT = 8'h08;
    localparam logic [7:0] RST_BUFFER_SPLIT = 8'h55;
    localparam logic [15:0] RST_PPP_AUTH_KIND = 16'h0000;
    localparam logic [7:0] RST_LCP_ECHO_INTERVAL = 8'h28;
    localparam logic [7:0] RST_LCP_MAGIC_VALUE = 8'h00;
    localparam logic [7:0] RST_SOCKET_MODE = 8'h00;

    // field positions
    localparam int FLAG_CONFLICT = 7;
    localparam int FLAG_FLAG_A = 6;
    localparam int FLAG_PPP_CLOSE = 5;
    localparam int FLAG_RESERVED = 4;
    localparam int MODE_MULTICAST = 7;
    localparam int MODE_FRAME_FILTER = 6;
    localparam int MODE_ACK_OR_IGMP = 5;
    localparam logic [7:0] FLAG_IMPLEMENTED = 8'he0;
    localparam logic [7:0] MODE_BITS_SOCK0 = 8'hef;
    localparam logic [7:0] MODE_BITS_OTHER = 8'haf;

    // authentication kinds
    localparam logic [15:0] AUTH_PAP = 16'hc023;
    localparam logic [15:0] AUTH_CHAP = 16'hc223;

    // buffer memory
    localparam logic [5:0] BUFFER_TOTAL_KB = 6'h08;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int RETRY_UNIT_NS = 100000;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_NS / CLK_PERIOD_NS;
    localparam int ECHO_UNIT_NS = 25000000;
    localparam int ECHO_UNIT_CYC = ECHO_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        PROTO_CLOSED = 4'b0000,
        PROTO_TCP = 4'b0001,
        PROTO_UDP = 4'b0010,
        PROTO_RAW_IP = 4'b0011,
        PROTO_RAW_ETHERNET = 4'b0100,
        PROTO_PPPOE = 4'b0101
    } ncc_proto_type;

    typedef struct packed {
        logic usable;
        logic [12:0] base;
        logic [3:0] size_kb;
    } ncc_alloc_type;

    typedef struct packed {
        ncc_proto_type proto;
        logic multicast;
        logic frame_filter_enable;
        logic no_delayed_ack;
        logic igmp_v1;
    } ncc_mode_type;

endpackage : ncc_pkg

// ===== src/ncc_regs.sv
/*
 * ncc_regs: common configuration and status registers, socket mode
 * registers, interrupt summary, retransmission timers, lcp echo timer
 * and buffer allocation.
 * assumes protocol engines on the same clock drive the event inputs
 * and a host on the plain register port.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - interrupt when flag set and mask set
// - masked flag still sets, no interrupt
// - mask bits 7,6,5 and 3..0 map
// - retry period is interval times 100us
// - retry interval stored high byte first
// - retransmit when peer response missing
// - timeout flag once retries exceed limit
// - receive split two bits per socket
// - size codes select 1,2,4,8 KB
// - allocate from socket 0 until full
// - split registers reset to 2KB each
// - transmit split same as receive
// - read-only auth kind, reset zero
// - echo interval is value times 25ms
// - capture unreachable ip and port
// - four mode registers, 0x100 apart
// - multicast igmp version bit
// - protocol field encoding
// - interrupt low while unmasked flag set
// - write-one clear; socket flags auto clear
module ncc_regs import ncc_pkg::*; #(
    parameter int ECHO_CYC = ECHO_UNIT_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data_q,
    output logic int_n_q,
    input wire logic conflict_evt,
    input wire logic flag_a_evt,
    input wire logic [31:0] flag_a_ip_in,
    input wire logic [15:0] flag_a_port_in,
    input wire logic ppp_close_evt,
    input wire logic [3:0] socket_flags_set,
    input wire logic auth_kind_evt,
    input wire logic [15:0] auth_kind_in,
    input wire logic [3:0] await_rsp,
    output logic [3:0] retransmit_q,
    output logic [3:0] timeout_q,
    input wire logic ppp_active,
    output logic lcp_echo_req_q,
    output logic [7:0] lcp_magic_value_q,
    output ncc_alloc_type [3:0] rx_alloc_q,
    output ncc_alloc_type [3:0] tx_alloc_q,
    output ncc_mode_type [3:0] mode_q
);

    function automatic ncc_alloc_type alloc_of(input logic [7:0] split, input int idx);
        logic [5:0] used;
        logic [3:0] kb;
        logic full;
        ncc_alloc_type a;
        used = '0;
        full = 1'b0;
        a = '0;
        for (int i = 0; i < 4; i++) begin
            kb = 4'h1 << split[2*i +: 2];
            if (!full && (used + 6'(kb) <= BUFFER_TOTAL_KB)) begin
                if (i == idx) begin
                    a.usable = 1'b1;
                    a.base = 13'({used, 10'h000});
                    a.size_kb = kb;
                end
                used = used + 6'(kb);
            end else begin
                full = 1'b1;
            end
        end
        return a;
    endfunction : alloc_of

    function automatic ncc_mode_type mode_of(input logic [7:0] raw, input int sock);
        ncc_mode_type m;
        logic [3:0] p;
        m = '0;
        p = raw[3:0];
        case (p)
            4'b0000: m.proto = PROTO_CLOSED;
            4'b0001: m.proto = PROTO_TCP;
            4'b0010: m.proto = PROTO_UDP;
            4'b0011: m.proto = PROTO_RAW_IP;
            4'b0100: m.proto = (sock == 0) ? PROTO_RAW_ETHERNET : PROTO_CLOSED;
            4'b0101: m.proto = (sock == 0) ? PROTO_PPPOE : PROTO_CLOSED;
            default: m.proto = PROTO_CLOSED;
        endcase
        m.multicast = raw[MODE_MULTICAST] && (m.proto == PROTO_UDP);
        m.frame_filter_enable = raw[MODE_FRAME_FILTER]
            && (m.proto == PROTO_RAW_ETHERNET);
        m.no_delayed_ack = raw[MODE_ACK_OR_IGMP] && (m.proto == PROTO_TCP);
        m.igmp_v1 = raw[MODE_ACK_OR_IGMP] && m.multicast;
        return m;
    endfunction : mode_of

    function automatic logic sock_hit(input logic [15:0] a, input int sock);
        return a == ADDR_SOCKET_MODE + 16'(sock) * SOCKET_STRIDE;
    endfunction : sock_hit

    logic [7:0] flags_q;
    logic [7:0] interrupt_mask_q;
    logic [15:0] retry_interval_q;
    logic [7:0] retry_limit_q;
    logic [7:0] rx_buffer_split_q;
    logic [7:0] tx_buffer_split_q;
    logic [15:0] ppp_auth_kind_q;
    logic [7:0] lcp_echo_interval_q;
    logic [31:0] unreachable_ip_q;
    logic [15:0] unreachable_port_q;
    logic [7:0] socket_mode_q [4];
    logic [7:0] rd_mux;
    logic [11:0] retry_pre_q;
    logic retry_tick;
    logic [15:0] ivl_cnt_q [4];
    logic [8:0] retries_q [4];
    logic [3:0] spent_q;
    logic [19:0] echo_pre_q;
    logic [7:0] echo_cnt_q;
    logic wr_flags;

    assign wr_flags = wr_stb && (addr == ADDR_SUMMARY_FLAGS);

    // host-writable configuration
    always_ff @(posedge clk) begin
        if (!resetn) begin
            retry_interval_q <= RST_RETRY_INTERVAL;
            retry_limit_q <= RST_RETRY_LIMIT;
            rx_buffer_split_q <= RST_BUFFER_SPLIT;
            tx_buffer_split_q <= RST_BUFFER_SPLIT;
        end else if (wr_stb) begin
            case (addr)
                ADDR_RETRY_INTERVAL_HI: retry_interval_q[15:8] <= wr_data;
                ADDR_RETRY_INTERVAL_LO: retry_interval_q[7:0] <= wr_data;
                ADDR_RETRY_LIMIT: retry_limit_q <= wr_data;
                ADDR_RX_BUFFER_SPLIT: rx_buffer_split_q <= wr_data;
                ADDR_TX_BUFFER_SPLIT: tx_buffer_split_q <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // interrupt mask, reserved bit held clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            interrupt_mask_q <= RST_INTERRUPT_MASK;
        end else if (wr_stb && addr == ADDR_INTERRUPT_MASK) begin
            interrupt_mask_q <= wr_data & ~(8'h01 << FLAG_RESERVED);
        end
    end

    // ppp link settings
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lcp_echo_interval_q <= RST_LCP_ECHO_INTERVAL;
            lcp_magic_value_q <= RST_LCP_MAGIC_VALUE;
        end else if (wr_stb && addr == ADDR_LCP_ECHO_INTERVAL) begin
            lcp_echo_interval_q <= wr_data;
        end else if (wr_stb && addr == ADDR_LCP_MAGIC_VALUE) begin
            lcp_magic_value_q <= wr_data;
        end
    end

    // socket mode registers
    always_ff @(posedge clk) begin
        for (int n = 0; n < 4; n++) begin
            if (!resetn) begin
                socket_mode_q[n] <= RST_SOCKET_MODE;
            end else if (wr_stb && sock_hit(addr, n)) begin
                socket_mode_q[n] <= wr_data & ((n == 0) ? MODE_BITS_SOCK0 : MODE_BITS_OTHER);
            end
        end
    end

    // summary flags, set wins over write-one clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags_q <= 8'h00;
        end else begin
            flags_q[FLAG_CONFLICT] <= conflict_evt
                || (flags_q[FLAG_CONFLICT] && !(wr_flags && wr_data[FLAG_CONFLICT]));
            flags_q[FLAG_FLAG_A] <= flag_a_evt
                || (flags_q[FLAG_FLAG_A] && !(wr_flags && wr_data[FLAG_FLAG_A]));
            flags_q[FLAG_PPP_CLOSE] <= ppp_close_evt
                || (flags_q[FLAG_PPP_CLOSE] && !(wr_flags && wr_data[FLAG_PPP_CLOSE]));
            flags_q[FLAG_RESERVED] <= 1'b0;
            flags_q[3:0] <= socket_flags_set;
        end
    end

    // interrupt output
    always_ff @(posedge clk) begin
        if (!resetn) begin
            int_n_q <= 1'b1;
        end else begin
            int_n_q <= ~|(flags_q & interrupt_mask_q);
        end
    end

    // unreachable destination capture
    always_ff @(posedge clk) begin
        if (!resetn) begin
            unreachable_ip_q <= 32'h0000_0000;
            unreachable_port_q <= 16'h0000;
        end else if (flag_a_evt) begin
            unreachable_ip_q <= flag_a_ip_in;
            unreachable_port_q <= flag_a_port_in;
        end
    end

    // agreed authentication kind, unknown kinds dropped
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ppp_auth_kind_q <= RST_PPP_AUTH_KIND;
        end else if (auth_kind_evt && (auth_kind_in == AUTH_PAP || auth_kind_in == AUTH_CHAP)) begin
            ppp_auth_kind_q <= auth_kind_in;
        end
    end

    // read mux, big-endian byte order
    always_comb begin
        rd_mux = 8'h00;
        case (addr)
            ADDR_SUMMARY_FLAGS: rd_mux = flags_q;
            ADDR_INTERRUPT_MASK: rd_mux = interrupt_mask_q;
            ADDR_RETRY_INTERVAL_HI: rd_mux = retry_interval_q[15:8];
            ADDR_RETRY_INTERVAL_LO: rd_mux = retry_interval_q[7:0];
            ADDR_RETRY_LIMIT: rd_mux = retry_limit_q;
            ADDR_RX_BUFFER_SPLIT: rd_mux = rx_buffer_split_q;
            ADDR_TX_BUFFER_SPLIT: rd_mux = tx_buffer_split_q;
            ADDR_PPP_AUTH_KIND_HI: rd_mux = ppp_auth_kind_q[15:8];
            ADDR_PPP_AUTH_KIND_LO: rd_mux = ppp_auth_kind_q[7:0];
            ADDR_LCP_ECHO_INTERVAL: rd_mux = lcp_echo_interval_q;
            ADDR_LCP_MAGIC_VALUE: rd_mux = lcp_magic_value_q;
            ADDR_UNREACHABLE_IP: rd_mux = unreachable_ip_q[31:24];
            ADDR_UNREACHABLE_IP + 16'h0001: rd_mux = unreachable_ip_q[23:16];
            ADDR_UNREACHABLE_IP + 16'h0002: rd_mux = unreachable_ip_q[15:8];
            ADDR_UNREACHABLE_IP + 16'h0003: rd_mux = unreachable_ip_q[7:0];
            ADDR_UNREACHABLE_PORT: rd_mux = unreachable_port_q[15:8];
            ADDR_UNREACHABLE_PORT + 16'h0001: rd_mux = unreachable_port_q[7:0];
            default: begin
                for (int n = 0; n < 4; n++) begin
                    if (sock_hit(addr, n)) begin
                        rd_mux = socket_mode_q[n];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data_q <= 8'h00;
        end else if (rd_stb) begin
            rd_data_q <= rd_mux;
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    // 100us retry tick
    assign retry_tick = (retry_pre_q == 12'(RETRY_UNIT_CYC - 1));

    always_ff @(posedge clk) begin
        if (!resetn || retry_tick) begin
            retry_pre_q <= 12'h000;
        end else begin
            retry_pre_q <= retry_pre_q + 12'h001;
        end
    end

    // per-socket retransmission timers
    always_ff @(posedge clk) begin
        for (int n = 0; n < 4; n++) begin
            if (!resetn || !await_rsp[n]) begin
                ivl_cnt_q[n] <= 16'h0000;
                retries_q[n] <= 9'h000;
                spent_q[n] <= 1'b0;
                retransmit_q[n] <= 1'b0;
                timeout_q[n] <= 1'b0;
            end else begin
                retransmit_q[n] <= 1'b0;
                timeout_q[n] <= 1'b0;
                if (retry_tick && !spent_q[n]) begin
                    if (ivl_cnt_q[n] + 16'h0001 >= retry_interval_q) begin
                        ivl_cnt_q[n] <= 16'h0000;
                        if (retries_q[n] >= {1'b0, retry_limit_q}) begin
                            timeout_q[n] <= 1'b1;
                            spent_q[n] <= 1'b1;
                        end else begin
                            retransmit_q[n] <= 1'b1;
                            retries_q[n] <= retries_q[n] + 9'h001;
                        end
                    end else begin
                        ivl_cnt_q[n] <= ivl_cnt_q[n] + 16'h0001;
                    end
                end
            end
        end
    end

    // lcp echo request timer
    always_ff @(posedge clk) begin
        if (!resetn || !ppp_active) begin
            echo_pre_q <= 20'h00000;
            echo_cnt_q <= 8'h00;
            lcp_echo_req_q <= 1'b0;
        end else begin
            lcp_echo_req_q <= 1'b0;
            if (echo_pre_q == 20'(ECHO_CYC - 1)) begin
                echo_pre_q <= 20'h00000;
                if (echo_cnt_q + 8'h01 >= lcp_echo_interval_q) begin
                    echo_cnt_q <= 8'h00;
                    lcp_echo_req_q <= (lcp_echo_interval_q != 8'h00);
                end else begin
                    echo_cnt_q <= echo_cnt_q + 8'h01;
                end
            end else begin
                echo_pre_q <= echo_pre_q + 20'h00001;
            end
        end
    end

    // receive buffer allocation
    always_ff @(posedge clk) begin
        for (int n = 0; n < 4; n++) begin
            if (!resetn) begin
                rx_alloc_q[n] <= '0;
            end else begin
                rx_alloc_q[n] <= alloc_of(rx_buffer_split_q, n);
            end
        end
    end

    // transmit buffer allocation
    always_ff @(posedge clk) begin
        for (int n = 0; n < 4; n++) begin
            if (!resetn) begin
                tx_alloc_q[n] <= '0;
            end else begin
                tx_alloc_q[n] <= alloc_of(tx_buffer_split_q, n);
            end
        end
    end

    // socket mode decode
    always_ff @(posedge clk) begin
        for (int n = 0; n < 4; n++) begin
            if (!resetn) begin
                mode_q[n] <= '0;
            end else begin
                mode_q[n] <= mode_of(socket_mode_q[n], n);
            end
        end
    end

endmodule : ncc_regs

`default_nettype wire

// ===== tb/ncc_engine_model.sv
/* ncc_engine_model: socket engines facing the register bank.
   assumes start, answer and clear pulses from the bench on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module ncc_engine_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] start,
    input wire logic [3:0] answer,
    input wire logic [3:0] clear,
    input wire logic [3:0] retransmit_q,
    input wire logic [3:0] timeout_q,
    output logic [3:0] await_rsp,
    output logic [3:0] socket_flags_set,
    output logic [7:0] retx_cnt
);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            await_rsp <= 4'h0;
            socket_flags_set <= 4'h0;
            retx_cnt <= 8'h00;
        end else begin
            // waits until the peer answers or the bank gives up
            await_rsp <= (await_rsp | start) & ~answer & ~timeout_q;
            // timeout flag kept until the host clears it
            socket_flags_set <= (socket_flags_set | timeout_q) & ~clear;
            retx_cnt <= retx_cnt + 8'($countones(retransmit_q));
        end
    end
endmodule : ncc_engine_model
`default_nettype wire

// ===== tb/ncc_regs_sva.sv
/* ncc_regs_chk: port-level assertions and covers for ncc_regs.
   assumes one clock, synchronous active-low reset, plain register port. */
`timescale 1ns/1ps
`default_nettype none
module ncc_regs_chk import ncc_pkg::*; #(
    parameter int ECHO_CYC = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data_q,
    input wire logic int_n_q,
    input wire logic flag_a_evt,
    input wire logic [3:0] socket_flags_set,
    input wire logic [3:0] await_rsp,
    input wire logic [3:0] retransmit_q,
    input wire logic [3:0] timeout_q,
    input wire logic ppp_active,
    input wire logic lcp_echo_req_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] mask_q;
    // shadow of the mask as the host wrote it, reserved bit 4 cleared
    always_ff @(posedge clk) begin
        if (!resetn) mask_q <= 8'h00;
        else if (wr_stb && addr == ADDR_INTERRUPT_MASK) mask_q <= wr_data & 8'hef;
    end
    chk_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data_q == 8'h00)
        else $error("read data not zero outside read");
    chk_mask_rsvd: assert property (rd_stb && addr == ADDR_INTERRUPT_MASK
        |=> rd_data_q[4] == 1'b0) else $error("mask bit 4 reads one");
    chk_mode_rsvd: assert property (rd_stb && addr == 16'h0500
        |=> rd_data_q[6] == 1'b0 && rd_data_q[4] == 1'b0) else $error("mode reserved set");
    chk_flag_a_irq: assert property (flag_a_evt && mask_q[6] && !wr_stb
        |-> ##2 !int_n_q) else $error("unmasked flag gave no interrupt");
    chk_masked_quiet: assert property (mask_q == 8'h00 [*3] |-> int_n_q)
        else $error("interrupt with all masked");
    chk_sock_irq: assert property ((socket_flags_set[1] && mask_q[1]) [*3]
        |-> !int_n_q) else $error("socket flag gave no interrupt");
    chk_retx_idle: assert property (!await_rsp[1] [*2]
        |-> !retransmit_q[1] && !timeout_q[1]) else $error("retry without waiting");
    chk_retx_gap: assert property (retransmit_q[1] |=> !retransmit_q[1] [*8])
        else $error("retransmits too close");
    chk_echo_off: assert property (!ppp_active [*2] |-> !lcp_echo_req_q)
        else $error("echo request while idle");
    chk_echo_gap: assert property (lcp_echo_req_q |=> !lcp_echo_req_q [*8])
        else $error("echo requests too close");
    cov_timeout: cover property (timeout_q[1]);
    cov_echo: cover property (lcp_echo_req_q);
    cov_irq: cover property ($fell(int_n_q));
endmodule : ncc_regs_chk
bind ncc_regs ncc_regs_chk #(.ECHO_CYC(ECHO_CYC)) u_chk (.clk(clk), .resetn(resetn),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
    .int_n_q(int_n_q), .flag_a_evt(flag_a_evt), .socket_flags_set(socket_flags_set),
    .await_rsp(await_rsp), .retransmit_q(retransmit_q), .timeout_q(timeout_q),
    .ppp_active(ppp_active), .lcp_echo_req_q(lcp_echo_req_q));
`default_nettype wire

// ===== tb/tb_ncc_regs.sv
/* tb_ncc_regs: register-port tests for ncc_regs.
   assumes the engine model on the far side and a short echo unit. */
`timescale 1ns/1ps
`default_nettype none
module tb_ncc_regs import ncc_pkg::*;;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic ppp_active = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [3:0] start = 4'h0;
    logic [3:0] answer = 4'h0;
    logic [3:0] clear = 4'h0;
    logic [15:0] auth_kind_in = 16'hc223;
    logic [7:0] rd_data_q, lcp_magic_value_q, retx_cnt;
    logic int_n_q, lcp_echo_req_q;
    logic [3:0] socket_flags_set, await_rsp, retransmit_q, timeout_q;
    ncc_alloc_type [3:0] rx_alloc_q, tx_alloc_q;
    ncc_mode_type [3:0] mode_q;
    int errors = 0;
    int checked = 0;
    int n;
    logic [15:0] ra[14] = '{16'h16, 16'h17, 16'h18, 16'h19, 16'h1a, 16'h1b, 16'h1c,
        16'h1d, 16'h28, 16'h29, 16'h2a, 16'h2f, 16'h400, 16'h700};
    logic [7:0] rv[14] = '{8'h00, 8'h07, 8'hd0, 8'h08, 8'h55, 8'h55, 8'h00, 8'h00,
        8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #12.5 clk = ~clk;
    ncc_regs #(.ECHO_CYC(10)) uut (.clk(clk), .resetn(resetn), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
        .int_n_q(int_n_q), .conflict_evt(ev[0]), .flag_a_evt(ev[1]),
        .flag_a_ip_in(32'hc0a8000b), .flag_a_port_in(16'h1388), .ppp_close_evt(ev[2]),
        .socket_flags_set(socket_flags_set), .auth_kind_evt(ev[3]),
        .auth_kind_in(auth_kind_in), .await_rsp(await_rsp), .retransmit_q(retransmit_q),
        .timeout_q(timeout_q), .ppp_active(ppp_active), .lcp_echo_req_q(lcp_echo_req_q),
        .lcp_magic_value_q(lcp_magic_value_q), .rx_alloc_q(rx_alloc_q),
        .tx_alloc_q(tx_alloc_q), .mode_q(mode_q));
    ncc_engine_model u_eng (.clk(clk), .resetn(resetn), .start(start), .answer(answer),
        .clear(clear), .retransmit_q(retransmit_q), .timeout_q(timeout_q),
        .await_rsp(await_rsp), .socket_flags_set(socket_flags_set), .retx_cnt(retx_cnt));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wr_data <= d;
    endtask : cyc
    task idle(input int k);
        repeat (k) cyc(1'b0, 1'b0, 16'h0000, 8'h00);
        #1;
    endtask : idle
    task wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask : wr
    task rdc(input logic [15:0] a, input logic [7:0] exp);
        cyc(1'b0, 1'b1, a, 8'h00);
        idle(1);
        chk(rd_data_q, exp);
    endtask : rdc
    task evp(input logic [3:0] e);
        idle(1);
        ev <= e;
        idle(1);
        ev <= 4'h0;
    endtask : evp
    task final_report;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #(25 * 40000);
        errors++;
        $display("watchdog expired");
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 14; i++) rdc(ra[i], rv[i]);
        chk(rx_alloc_q[3], {1'b1, 13'h1800, 4'h2});
        chk(tx_alloc_q[1], {1'b1, 13'h0800, 4'h2});
        $display("test reset values done");
        wr(16'h16, 8'hef);
        rdc(16'h16, 8'hef);
        wr(16'h17, 8'h0f);
        wr(16'h18, 8'ha0);
        rdc(16'h17, 8'h0f);
        rdc(16'h18, 8'ha0);
        wr(16'h1c, 8'hff);
        rdc(16'h1c, 8'h00);
        wr(16'h400, 8'hff);
        rdc(16'h400, 8'hef);
        wr(16'h500, 8'hff);
        rdc(16'h500, 8'haf);
        wr(16'h30, 8'hff);
        rdc(16'h30, 8'h00);
        wr(16'h29, 8'h5a);
        idle(2);
        chk(lcp_magic_value_q, 8'h5a);
        $display("test access kinds done");
        wr(16'h1a, 8'haa);
        wr(16'h1b, 8'he4);
        idle(3);
        chk(rx_alloc_q[1], {1'b1, 13'h1000, 4'h4});
        chk(rx_alloc_q[2].usable, 1'b0);
        chk(tx_alloc_q[0], {1'b1, 13'h0000, 4'h1});
        chk(tx_alloc_q[1], {1'b1, 13'h0400, 4'h2});
        chk(tx_alloc_q[2], {1'b1, 13'h0c00, 4'h4});
        chk(tx_alloc_q[3].usable, 1'b0);
        wr(16'h1a, 8'h03);
        idle(3);
        chk(rx_alloc_q[0], {1'b1, 13'h0000, 4'h8});
        chk(rx_alloc_q[1].usable, 1'b0);
        $display("test buffer split done");
        for (int c = 0; c < 6; c++) begin
            wr(16'h400, 8'(c));
            idle(2);
            chk(mode_q[0].proto, 4'(c));
        end
        wr(16'h500, 8'h04);
        idle(2);
        chk(mode_q[1].proto, PROTO_CLOSED);
        wr(16'h400, 8'h44);
        wr(16'h500, 8'h21);
        wr(16'h600, 8'ha2);
        idle(2);
        chk(mode_q[0].frame_filter_enable, 1'b1);
        chk(mode_q[1].no_delayed_ack, 1'b1);
        chk({mode_q[2].multicast, mode_q[2].igmp_v1}, 2'b11);
        $display("test socket modes done");
        wr(16'h16, 8'h00);
        evp(4'h1);
        idle(2);
        chk(int_n_q, 1'b1);
        rdc(16'h15, 8'h80);
        wr(16'h16, 8'h80);
        idle(2);
        chk(int_n_q, 1'b0);
        wr(16'h15, 8'h80);
        idle(2);
        chk(int_n_q, 1'b1);
        wr(16'h16, 8'h60);
        evp(4'h2);
        idle(2);
        chk(int_n_q, 1'b0);
        rdc(16'h2a, 8'hc0);
        rdc(16'h2d, 8'h0b);
        rdc(16'h2e, 8'h13);
        rdc(16'h2f, 8'h88);
        wr(16'h15, 8'h40);
        evp(4'h4);
        rdc(16'h15, 8'h20);
        chk(int_n_q, 1'b0);
        wr(16'h15, 8'h20);
        idle(2);
        chk(int_n_q, 1'b1);
        evp(4'h8);
        rdc(16'h1c, 8'hc2);
        rdc(16'h1d, 8'h23);
        auth_kind_in <= 16'h1234;
        evp(4'h8);
        rdc(16'h1c, 8'hc2);
        $display("test interrupts done");
        wr(16'h17, 8'h00);
        wr(16'h18, 8'h01);
        wr(16'h19, 8'h01);
        wr(16'h16, 8'h02);
        idle(1);
        start <= 4'h6;
        idle(5);
        start <= 4'h0;
        answer <= 4'h4;
        idle(1);
        answer <= 4'h0;
        for (n = 0; n < 20000 && socket_flags_set[1] !== 1'b1; n++) idle(1);
        chk(socket_flags_set[1], 1'b1);
        chk(retx_cnt, 8'h01);
        idle(3);
        chk(int_n_q, 1'b0);
        rdc(16'h15, 8'h02);
        clear <= 4'h2;
        idle(1);
        clear <= 4'h0;
        idle(3);
        chk(int_n_q, 1'b1);
        $display("test retry done");
        wr(16'h28, 8'h03);
        idle(1);
        ppp_active <= 1'b1;
        for (n = 0; n < 200 && lcp_echo_req_q !== 1'b1; n++) idle(1);
        for (n = 1; n < 200; n++) begin
            idle(1);
            if (lcp_echo_req_q === 1'b1) break;
        end
        chk(n, 30);
        ppp_active <= 1'b0;
        idle(3);
        $display("test echo timer done");
        final_report();
    end
endmodule : tb_ncc_regs
`default_nettype wire
